// File: src/rsc_defs.svh
// constants for the reset sequencer and system clock selector
// assumes inclusion by bare name from the reset sequencer design file
`ifndef RSC_DEFS_SVH
`define RSC_DEFS_SVH

// register addresses on the special register port
`define RSC_EXT_OSC_ADDR      8'hB1
`define RSC_INT_OSC_ADDR      8'hB2

// external oscillator control fields
`define RSC_XV_BIT            7
`define RSC_XMODE_HI          6
`define RSC_XMODE_LO          4
`define RSC_XFREQ_HI          2
`define RSC_XFREQ_LO          0
`define RSC_EXT_OSC_RESET     8'h00

// internal oscillator control fields
`define RSC_SYSCLK_SOURCE_SELECT_BIT         0
`define RSC_INT_EN_BIT        2
`define RSC_INT_OSC_RESET     8'h04
`define RSC_INT_OSC_WMASK     8'h05

// port and program defaults
`define RSC_PORT_LATCH_RESET  8'hFF
`define RSC_FETCH_ADDR_RESET  16'h0000

// timing: watchdog prescale and break-before-make gap
`define RSC_WDT_DIV           4'hC
`define RSC_SW_GAP_NS         10
`define RSC_CLK_PERIOD_NS     5
`define RSC_SW_GAP_CYC        ((`RSC_SW_GAP_NS + `RSC_CLK_PERIOD_NS - 1) / `RSC_CLK_PERIOD_NS)

`endif

// File: src/rsc_pkg.sv
// types for the reset sequencer and system clock selector
// assumes rsc_defs.svh supplies all numeric constants
package rsc_pkg;

    // reset exit sequence, gray along hold -> wait -> run
    typedef enum logic [1:0] {
        RSC_HOLD = 2'b00,
        RSC_WAIT = 2'b01,
        RSC_RUN  = 2'b11
    } rsc_state_type;

    // decoded external oscillator configuration
    typedef enum logic [1:0] {
        RSC_XOFF  = 2'b00,
        RSC_XCMOS = 2'b01,
        RSC_XRC   = 2'b10,
        RSC_XTAL  = 2'b11
    } rsc_xmode_type;

endpackage

// File: src/rsc_sync2.sv
// two flip-flop level synchroniser, one per bit
// assumes inputs come from another clock domain or a pin
`timescale 1ns/100ps

module rsc_sync2 #(
    parameter int          WIDTH     = 1,
    parameter logic [15:0] RESET_VAL = 16'h0000
) (
    // clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    // asynchronous in, synchronous out
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    genvar g;
    // first stage is read only by the second stage
    generate
        for (g = 0; g < WIDTH; g++) begin : g_bit
            logic meta_reg;
            logic sync_reg;
            always_ff @(posedge i_clk or negedge i_reset_n) begin
                if (!i_reset_n) begin
                    meta_reg <= RESET_VAL[g];
                    sync_reg <= RESET_VAL[g];
                end else begin
                    meta_reg <= i_async[g];
                    sync_reg <= meta_reg;
                end
            end
            assign o_sync[g] = sync_reg;
        end
    endgenerate

endmodule // rsc_sync2

// File: src/rsc_reset_sysclk.sv
// reset entry/exit sequencer and system clock source selector
// assumes i_clk is the running system clock and i_reset_n the combined reset
// Operation
// - reset halts execution, defaults registers, disables interrupts
// - reset leaves data memory intact, stack pointer reset (this module has no stack pointer output)
// - port latches reset to ones, open-drain
// - weak pull-ups enabled during and after reset
// - supply resets drive reset pin low
// - exit clears program counter, selects internal oscillator
// - watchdog enabled, clocked by system clock/12
// - fetch at zero once clock stable
// - crystal mode claims port0 pins two, three
// - rc, capacitor, cmos modes claim pin three only
// - select bit one chooses external system clock
// - clock source may switch any time
// - one write enables and selects internal oscillator
// - valid flag set only when oscillator settled
// - mode 10x selects capacitor or rc
`timescale 1ns/100ps
`include "rsc_defs.svh"

module rsc_reset_sysclk (
    // clock and reset
    input  wire logic        i_clk,
    input  wire logic        i_reset_n,
    // reset cause and oscillator status, asynchronous
    input  wire logic        i_supply_reset,
    input  wire logic        i_int_osc_stable,
    input  wire logic        i_ext_osc_settled,
    // special register port
    input  wire logic [7:0]  i_reg_addr,
    input  wire logic        i_reg_wr,
    input  wire logic [7:0]  i_reg_wdata,
    output logic      [7:0]  o_reg_rdata,
    // core control
    output logic             o_cpu_run,
    output logic             o_reg_defaults,
    output logic             o_irq_timer_disable,
    output logic             o_pc_clear,
    output logic      [15:0] o_fetch_addr,
    // port defaults and reset pin
    output logic      [7:0]  o_port_latch,
    output logic             o_port_open_drain,
    output logic             o_weak_pullup_en,
    output logic             o_rst_pin_out,
    output logic             o_rst_pin_oe,
    // watchdog
    output logic             o_wdt_enable,
    output logic             o_wdt_tick,
    // oscillator control
    output logic             o_int_osc_en,
    output logic             o_sel_int_clk,
    output logic             o_sel_ext_clk,
    output logic             o_ext_osc_drive_en,
    output logic      [1:0]  o_ext_osc_mode,
    output logic      [2:0]  o_ext_osc_freq_control,
    output logic             o_ext_clk_gate_en,
    output logic             o_port0_pin_two_claim,
    output logic             o_port0_pin_three_claim
);

    // decode of the three-bit mode field
    function automatic rsc_pkg::rsc_xmode_type xmode_decode(input logic [2:0] f);
        rsc_pkg::rsc_xmode_type m;
        m = rsc_pkg::RSC_XOFF;
        if (f[2:1] == 2'b00)
            m = rsc_pkg::RSC_XOFF;
        else if (f[2:1] == 2'b01)
            m = rsc_pkg::RSC_XCMOS;
        else if (f[2:1] == 2'b10)
            m = rsc_pkg::RSC_XRC;
        else
            m = rsc_pkg::RSC_XTAL;
        return m;
    endfunction

    // synchronised asynchronous inputs; supply cause assumed until known
    logic [2:0] sync_in;
    logic       supply_s;
    logic       int_stable_s;
    logic       ext_settled_s;

    rsc_sync2 #(
        .WIDTH     (3),
        .RESET_VAL (16'h0004)
    ) u_sync (
        .i_clk     (i_clk),
        .i_reset_n (i_reset_n),
        .i_async   ({i_supply_reset, i_int_osc_stable, i_ext_osc_settled}),
        .o_sync    (sync_in)
    );

    assign supply_s      = sync_in[2];
    assign int_stable_s  = sync_in[1];
    assign ext_settled_s = sync_in[0];

    // registers
    rsc_pkg::rsc_state_type state_reg;
    rsc_pkg::rsc_state_type state_next;
    logic [2:0] xmode_reg;
    logic [2:0] xfreq_reg;
    logic [7:0] int_ctl_reg;
    logic       xvalid_reg;
    logic [3:0] wdt_cnt_reg;
    logic [1:0] gap_cnt_reg;
    logic       eff_ext_reg;

    // register decode
    wire        wr_ext = i_reg_wr && (i_reg_addr == `RSC_EXT_OSC_ADDR);
    wire        wr_int = i_reg_wr && (i_reg_addr == `RSC_INT_OSC_ADDR);
    wire        in_reset = (state_next != rsc_pkg::RSC_RUN);  // pin lets go as run starts
    wire rsc_pkg::rsc_xmode_type xmode = xmode_decode(xmode_reg);
    wire        xoff = (xmode == rsc_pkg::RSC_XOFF);
    wire        want_ext = int_ctl_reg[`RSC_SYSCLK_SOURCE_SELECT_BIT];
    wire        switching = (want_ext != eff_ext_reg);
    wire [7:0]  ext_rd = {xvalid_reg, xmode_reg, 1'b0, xfreq_reg};
    wire [7:0]  rd_mux = (i_reg_addr == `RSC_EXT_OSC_ADDR) ? ext_rd :
                         (i_reg_addr == `RSC_INT_OSC_ADDR) ? int_ctl_reg : 8'h00;
    wire        wdt_wrap = (wdt_cnt_reg == (`RSC_WDT_DIV - 4'h1));

    // reset exit: hold one cycle, then wait for a stable clock
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            rsc_pkg::RSC_HOLD: state_next = rsc_pkg::RSC_WAIT;
            rsc_pkg::RSC_WAIT:
                if (int_stable_s)
                    state_next = rsc_pkg::RSC_RUN;
            rsc_pkg::RSC_RUN:  state_next = rsc_pkg::RSC_RUN;
            default:           state_next = rsc_pkg::RSC_HOLD;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            state_reg <= rsc_pkg::RSC_HOLD;
        else
            state_reg <= state_next;
    end

    // core control; data memory has no path from here, so it survives
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_cpu_run           <= 1'b0;
            o_reg_defaults      <= 1'b1;
            o_irq_timer_disable <= 1'b1;
            o_pc_clear          <= 1'b1;
            o_fetch_addr        <= `RSC_FETCH_ADDR_RESET;
        end else begin
            o_cpu_run           <= (state_next == rsc_pkg::RSC_RUN);
            o_reg_defaults      <= (state_next != rsc_pkg::RSC_RUN);
            o_irq_timer_disable <= (state_next != rsc_pkg::RSC_RUN);
            o_pc_clear          <= (state_next != rsc_pkg::RSC_RUN);
            o_fetch_addr        <= `RSC_FETCH_ADDR_RESET;
        end
    end

    // port defaults; held the same in reset and while running, nothing takes over
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_port_latch      <= `RSC_PORT_LATCH_RESET;
            o_port_open_drain <= 1'b1;
            o_weak_pullup_en  <= 1'b1;
        end else begin
            o_port_latch      <= `RSC_PORT_LATCH_RESET;
            o_port_open_drain <= 1'b1;
            o_weak_pullup_en  <= 1'b1;
        end
    end

    // reset pin drive low while in reset for supply-type causes
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_rst_pin_out <= 1'b0;
            o_rst_pin_oe  <= 1'b1;
        end else begin
            o_rst_pin_out <= 1'b0;
            o_rst_pin_oe  <= in_reset && supply_s;
        end
    end

    // watchdog prescaler, /12 of the system clock
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_wdt_enable <= 1'b1;
            wdt_cnt_reg  <= 4'h0;
            o_wdt_tick   <= 1'b0;
        end else begin
            o_wdt_enable <= 1'b1;
            wdt_cnt_reg  <= wdt_wrap ? 4'h0 : wdt_cnt_reg + 4'h1;
            o_wdt_tick   <= wdt_wrap;
        end
    end

    // oscillator control registers; writable at any time
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            int_ctl_reg <= `RSC_INT_OSC_RESET;
            xmode_reg   <= 3'(`RSC_EXT_OSC_RESET >> `RSC_XMODE_LO);
            xfreq_reg   <= 3'h0;
        end else begin
            if (wr_int)
                int_ctl_reg <= i_reg_wdata & `RSC_INT_OSC_WMASK;
            if (wr_ext) begin
                xmode_reg <= i_reg_wdata[`RSC_XMODE_HI:`RSC_XMODE_LO];
                xfreq_reg <= i_reg_wdata[`RSC_XFREQ_HI:`RSC_XFREQ_LO];
            end
        end
    end

    // valid flag follows the settled status, forced low when off
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            xvalid_reg <= 1'b0;
        else
            xvalid_reg <= ext_settled_s && !xoff;
    end

    // break-before-make: both selects low for the gap, then the new one
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            eff_ext_reg   <= 1'b0;
            gap_cnt_reg   <= 2'h0;
            o_sel_int_clk <= 1'b1;
            o_sel_ext_clk <= 1'b0;
        end else begin
            if (!switching) begin
                gap_cnt_reg   <= 2'h0;
                o_sel_int_clk <= !eff_ext_reg;
                o_sel_ext_clk <= eff_ext_reg;
            end else begin
                o_sel_int_clk <= 1'b0;
                o_sel_ext_clk <= 1'b0;
                if (gap_cnt_reg == 2'(`RSC_SW_GAP_CYC)) begin
                    eff_ext_reg <= want_ext;
                    gap_cnt_reg <= 2'h0;
                end else begin
                    gap_cnt_reg <= gap_cnt_reg + 2'h1;
                end
            end
        end
    end

    // external oscillator drive and pin ownership
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            o_int_osc_en            <= 1'b1;
            o_ext_osc_drive_en      <= 1'b0;
            o_ext_osc_mode          <= 2'b00;
            o_ext_osc_freq_control  <= 3'h0;
            o_ext_clk_gate_en       <= 1'b0;
            o_port0_pin_two_claim   <= 1'b0;
            o_port0_pin_three_claim <= 1'b0;
        end else begin
            o_int_osc_en            <= int_ctl_reg[`RSC_INT_EN_BIT];
            o_ext_osc_drive_en      <= !xoff;
            o_ext_osc_mode          <= xmode;
            o_ext_osc_freq_control  <= xfreq_reg;
            o_ext_clk_gate_en       <= !xoff;
            o_port0_pin_two_claim   <= (xmode == rsc_pkg::RSC_XTAL);
            o_port0_pin_three_claim <= !xoff;
        end
    end

    // registered read data, unmapped addresses read zero
    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n)
            o_reg_rdata <= 8'h00;
        else
            o_reg_rdata <= rd_mux;
    end

endmodule // rsc_reset_sysclk

// File: verif/rsc_osc_model.sv
// external oscillator stand-in: settles some cycles after its drive is enabled
// assumes drive enable comes from the selector, settled goes back to it
`timescale 1ns/100ps

module rsc_osc_model #(
    parameter int SETTLE_CYC = 20
) (
    // clock and drive enable in
    input  wire logic i_clk,
    input  wire logic i_drive_en,
    // settled status out
    output logic      o_settled
);
    int cnt_reg = 0;

    initial o_settled = 1'b0;

    // start-up count, flag false until it runs out
    always @(posedge i_clk) begin
        cnt_reg <= i_drive_en ? ((cnt_reg < SETTLE_CYC) ? cnt_reg + 1 : cnt_reg) : 0;
        o_settled <= i_drive_en && (cnt_reg >= SETTLE_CYC);
    end
endmodule // rsc_osc_model

// File: verif/rsc_reset_sysclk_assertions.sv
// concurrent checks on the reset sequencer and clock selector ports
// assumes one clock domain, bound into every rsc_reset_sysclk
`timescale 1ns/100ps

module rsc_reset_sysclk_assertions (
    input wire logic        i_clk,
    input wire logic        i_reset_n,
    input wire logic [7:0]  i_reg_addr,
    input wire logic        i_reg_wr,
    input wire logic [7:0]  i_reg_wdata,
    input wire logic        o_cpu_run,
    input wire logic        o_pc_clear,
    input wire logic [15:0] o_fetch_addr,
    input wire logic [7:0]  o_port_latch,
    input wire logic        o_port_open_drain,
    input wire logic        o_weak_pullup_en,
    input wire logic        o_rst_pin_out,
    input wire logic        o_rst_pin_oe,
    input wire logic        o_wdt_tick,
    input wire logic        o_sel_int_clk,
    input wire logic        o_sel_ext_clk,
    input wire logic        o_ext_osc_drive_en,
    input wire logic [1:0]  o_ext_osc_mode,
    input wire logic        o_ext_clk_gate_en,
    input wire logic        o_port0_pin_two_claim,
    input wire logic        o_port0_pin_three_claim
);
    default clocking @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    // steps of a source change: both selects low for three cycles; a write that selects external
    sequence s_gap;
        (!o_sel_int_clk && !o_sel_ext_clk)[*3];
    endsequence
    sequence s_ext_wr;
        i_reg_wr && i_reg_addr == 8'hB2 && i_reg_wdata[0];
    endsequence

    property p_halt;
        !o_cpu_run |-> o_pc_clear;
    endproperty
    a_halt: assert property (p_halt) else $error("pc not held while halted");
    property p_port;
        o_port_latch == 8'hFF && o_port_open_drain && o_weak_pullup_en;
    endproperty
    a_port: assert property (p_port) else $error("port defaults lost");
    property p_rst_pin;
        o_rst_pin_oe |-> !o_cpu_run && !o_rst_pin_out;
    endproperty
    a_rst_pin: assert property (p_rst_pin) else $error("reset pin driven while running");
    property p_start;
        $rose(o_cpu_run) |-> o_sel_int_clk && o_fetch_addr == 16'h0000;
    endproperty
    a_start: assert property (p_start) else $error("bad start state");
    property p_tick;
        o_wdt_tick |=> (!o_wdt_tick)[*8] ##1 (!o_wdt_tick)[*3] ##1 o_wdt_tick;
    endproperty
    a_tick: assert property (p_tick) else $error("watchdog tick not every 12");
    property p_claim;
        o_port0_pin_two_claim == (o_ext_osc_mode == 2'b11)
            && o_port0_pin_three_claim == (o_ext_osc_mode != 2'b00);
    endproperty
    a_claim: assert property (p_claim) else $error("pin claim mismatch");
    property p_mode;
        logic [1:0] m;
        (i_reg_wr && i_reg_addr == 8'hB1, m = i_reg_wdata[6:5]) |-> ##2 o_ext_osc_mode == m;
    endproperty
    a_mode: assert property (p_mode) else $error("mode decode wrong");
    property p_off;
        o_ext_osc_mode == 2'b00 |-> !o_ext_clk_gate_en && !o_ext_osc_drive_en;
    endproperty
    a_off: assert property (p_off) else $error("oscillator active while off");
    property p_gap;
        $fell(o_sel_int_clk) || $fell(o_sel_ext_clk) |-> s_gap;
    endproperty
    a_gap: assert property (p_gap) else $error("switch gap too short");
    property p_one_hot;
        !(o_sel_int_clk && o_sel_ext_clk);
    endproperty
    a_one_hot: assert property (p_one_hot) else $error("both sources selected");
    property p_sel_ext;
        s_ext_wr |-> ##[1:8] o_sel_ext_clk;
    endproperty
    a_sel_ext: assert property (p_sel_ext) else $error("external select missing");
endmodule // rsc_reset_sysclk_assertions

bind rsc_reset_sysclk rsc_reset_sysclk_assertions u_chk (.*);

// File: verif/rsc_reset_sysclk_tb_top.sv
// self-checking bench for the reset sequencer and clock selector
// assumes the oscillator model answers the external drive enable
`timescale 1ns/100ps

module rsc_reset_sysclk_tb_top;
    logic        i_clk = 1'b0, i_reset_n = 1'b0, i_supply_reset = 1'b1, i_int_osc_stable = 1'b0;
    logic        i_ext_osc_settled, i_reg_wr = 1'b0;
    logic [7:0]  i_reg_addr = 8'h00, i_reg_wdata = 8'h00, o_reg_rdata, o_port_latch;
    logic        o_cpu_run, o_reg_defaults, o_irq_timer_disable, o_pc_clear, o_port_open_drain;
    logic        o_weak_pullup_en, o_rst_pin_out, o_rst_pin_oe, o_wdt_enable, o_wdt_tick;
    logic        o_int_osc_en, o_sel_int_clk, o_sel_ext_clk, o_ext_osc_drive_en, o_ext_clk_gate_en;
    logic        o_port0_pin_two_claim, o_port0_pin_three_claim;
    logic [15:0] o_fetch_addr;
    logic [1:0]  o_ext_osc_mode;
    logic [2:0]  o_ext_osc_freq_control;
    logic [31:0] seed = 32'hB24616CA;
    int          num_errors = 0;
    int          num_checks = 0;

    rsc_reset_sysclk DUT (.*);
    rsc_osc_model u_osc (.i_clk(i_clk), .i_drive_en(o_ext_osc_drive_en),
                         .o_settled(i_ext_osc_settled));

    always #2.5 i_clk = ~i_clk;

    // xorshift, repeatable from the fixed seed
    function automatic logic [31:0] xs(logic [31:0] s);
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction

    // readback: valid on top, bit3 always zero
    function automatic logic [7:0] exp_ext(logic [7:0] w, logic v);
        return {v, w[6:4], 1'b0, w[2:0]};
    endfunction

    task automatic chk(logic [23:0] got, logic [23:0] exp, string what);
        num_checks++;
        if (got !== exp) begin
            num_errors++;
            $display("[ERR] %0t %s got %h exp %h", $time, what, got, exp);
        end
    endtask

    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    // bounded wait; running out ends the run
    task automatic wait_sig(ref logic s, input logic v, input int lim);
        for (int k = 0; k < lim && s !== v; k++) begin
            @(posedge i_clk);
            #1;
        end
        if (s !== v) begin
            num_errors++;
            $display("[ERR] %0t wait ran out", $time);
            wrap_up();
        end
    endtask

    task automatic wr_reg(logic [7:0] a, logic [7:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        i_reg_wr <= 1'b1;
        i_reg_wdata <= d;
        @(posedge i_clk);
        i_reg_wr <= 1'b0;
    endtask

    // one cycle read latency
    task automatic rd_reg(logic [7:0] a, output logic [7:0] d);
        @(posedge i_clk);
        i_reg_addr <= a;
        @(posedge i_clk);
        #1 d = o_reg_rdata;
    endtask

    initial begin
        logic [7:0] d;
        logic [7:0] w;
        int n;
        // reset entry, supply cause, internal oscillator not yet stable
        repeat (4) @(posedge i_clk);
        chk({o_port_latch, o_port_open_drain, o_weak_pullup_en}, 10'h3FF, "defaults");
        chk({o_rst_pin_oe, o_rst_pin_out, o_sel_int_clk, o_cpu_run}, 4'hA, "rst pin");
        chk({o_irq_timer_disable, o_reg_defaults, o_wdt_enable}, 3'h7, "halted");
        i_reset_n <= 1'b1;
        repeat (6) @(posedge i_clk);
        #1 chk({o_cpu_run, o_rst_pin_oe}, 2'h1, "held");
        i_int_osc_stable <= 1'b1;
        i_supply_reset <= 1'b0;
        wait_sig(o_cpu_run, 1'b1, 20);
        @(posedge i_clk);
        #1 chk({o_reg_defaults, o_irq_timer_disable, o_fetch_addr, o_pc_clear, o_rst_pin_oe,
                o_sel_int_clk}, 21'h1, "run");
        $display("test reset done");
        // watchdog period
        wait_sig(o_wdt_tick, 1'b1, 20);
        for (n = 1; n < 20; n++) begin
            @(posedge i_clk);
            #1 if (o_wdt_tick === 1'b1) break;
        end
        chk(n, 12, "wdt period");
        rd_reg(8'hB1, d);
        chk(d, 8'h00, "ext reset");
        rd_reg(8'hB2, d);
        chk(d, 8'h04, "int reset");
        wr_reg(8'hB4, 8'hFF);
        rd_reg(8'hB4, d);
        chk(d, 8'h00, "unmapped");
        $display("test registers done");
        // every mode, random frequency and read-only bits
        for (n = 0; n < 8; n++) begin
            seed = xs(seed);
            w = {seed[7], n[2:0], seed[3:0]};
            wr_reg(8'hB1, w);
            rd_reg(8'hB1, d);
            if (n == 2) chk(d[7], 1'b0, "early valid");
            for (int k = 0; k < 60 && d[7] !== (n > 1); k++) rd_reg(8'hB1, d);
            chk(d, exp_ext(w, n > 1), "ext readback");
            chk({o_port0_pin_two_claim, o_port0_pin_three_claim, o_ext_osc_mode, o_ext_osc_drive_en,
                 o_ext_clk_gate_en, o_ext_osc_freq_control},
                {n > 5, n > 1, n[2:1], n > 1, n > 1, w[2:0]}, "mode");
        end
        $display("test modes done");
        // switch to the settled crystal, then back in one write
        wr_reg(8'hB2, 8'hFF);
        wait_sig(o_sel_int_clk, 1'b0, 10);
        for (n = 0; n < 10 && o_sel_ext_clk !== 1'b1; n++) begin
            @(posedge i_clk);
            #1;
        end
        chk(n, 3, "switch gap");
        rd_reg(8'hB2, d);
        chk(d, 8'h05, "int mask");
        wr_reg(8'hB2, 8'h01);
        @(posedge i_clk);
        #1 chk(o_int_osc_en, 1'b0, "int off");
        wr_reg(8'hB2, 8'h04);
        wait_sig(o_sel_int_clk, 1'b1, 10);
        chk({o_int_osc_en, o_sel_ext_clk}, 2'h2, "int back");
        $display("test switch done");
        // second reset while running on the internal oscillator, crystal mode still set
        @(posedge i_clk);
        i_reset_n <= 1'b0;
        repeat (4) @(posedge i_clk);
        #1 chk({o_sel_int_clk, o_sel_ext_clk, o_cpu_run}, 3'h4, "rerun");
        i_reset_n <= 1'b1;
        wait_sig(o_cpu_run, 1'b1, 20);
        rd_reg(8'hB1, d);
        chk(d, 8'h00, "ext after rst");
        $display("test second reset done");
        wrap_up();
    end
endmodule // rsc_reset_sysclk_tb_top
